// ===== xbarb_arbiter.v
`timescale 1ns/10ps
`include "xbarb_map.vh"
// Contract
// - two independent arbiters, one per slave bus, five masters each
// - each request carries a two-bit priority, 11 highest
// - highest request priority wins outright
// - request-priority ties broken by internal master priority
// - memory-port request-priority level enabled by control bit 24
// - per-bus arbitration register, reset from attribute inputs
// - register holds five priority fields and a two-bit mode
// - arbitration uses an internal copy seeded from the register
// - register read returns written or attribute value only
// - lru: winner goes lowest, those below move up one
// - lru update after every grant, even request-priority decided
// - round robin rotates ring so winner becomes zero
// - fixed mode never changes internal priorities
// - lock sampled at grant; locks when that bus has no reads or writes outstanding
// - locked address valid waits until slave bus drains
// - lock covers both read and write halves
// - only the two slave-bus ports have lock inputs
// - winning lock blocks other masters until granted and released
// - lock grant drives address valid with downstream lock
// - lock drop ends lock; block until pending transfers done
module xbarb_arbiter (
   input wire clk,                      // system clock
   input wire nrst,                     // async reset, low
   input wire [31:0] attr_master_cfg,   // attribute reset value, master bus
   input wire [31:0] attr_memory_cfg,   // attribute reset value, memory port
   input wire reg_rd,                   // control register read strobe
   input wire reg_wr,                   // control register write strobe
   input wire [9:0] reg_addr,           // control register index
   input wire [31:0] reg_wdata,         // write data
   output reg [31:0] reg_rdata_r,       // read data
   output reg reg_ack_r,                // access acknowledge
   input wire [4:0] mb_req,             // requests for master bus port
   input wire [4:0] mc_req,             // requests for memory controller port
   input wire [9:0] request_priority_bus, // 2 bits per master
   input wire [1:0] master_lock_request, // slave-bus ports 0 and 1 only
   input wire [1:0] slave_address_ack,  // per bus: master, memory
   input wire [1:0] slave_read_complete, // per bus read completion
   input wire [1:0] slave_write_complete, // per bus write completion
   output wire [1:0] primary_address_valid, // per bus
   output wire [1:0] downstream_lock_output, // per bus
   output wire [5:0] grant_master       // 3-bit winner per bus
);
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   reg [31:0] master_bus_arbitration_config_r;
   reg [31:0] memory_port_arbitration_config_r;
   reg [31:0] memory_interface_control_r;
   reg [1:0] seeded_r;
   wire wr_mb = reg_wr && reg_addr == `XBARB_OFS_MASTER_CFG;
   wire wr_mc = reg_wr && reg_addr == `XBARB_OFS_MEMORY_CFG;
   // attributes are captured on the first clock after reset release
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         master_bus_arbitration_config_r <= 32'h0000_0000;
         memory_port_arbitration_config_r <= 32'h0000_0000;
         memory_interface_control_r <= `XBARB_MIC_RESET;
         seeded_r <= 2'b00;
      end else begin
         seeded_r <= {seeded_r[0], 1'b1};
         if (!seeded_r[0]) begin
            master_bus_arbitration_config_r <= attr_master_cfg;
            memory_port_arbitration_config_r <= attr_memory_cfg;
         end else begin
            if (wr_mb)
               master_bus_arbitration_config_r <= reg_wdata;
            if (wr_mc)
               memory_port_arbitration_config_r <= reg_wdata;
         end
         if (reg_wr && reg_addr == `XBARB_OFS_MEMORY_INTERFACE_CONTROL)
            memory_interface_control_r <= reg_wdata;
      end
   end
   // read returns stored value only, never working copies
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata_r <= 32'h0000_0000;
         reg_ack_r <= 1'b0;
      end else begin
         reg_ack_r <= reg_rd | reg_wr;
         case (reg_addr)
            `XBARB_OFS_MASTER_CFG: reg_rdata_r <= reg_rd ? master_bus_arbitration_config_r : 32'h0000_0000;
            `XBARB_OFS_MEMORY_CFG: reg_rdata_r <= reg_rd ? memory_port_arbitration_config_r : 32'h0000_0000;
            `XBARB_OFS_MEMORY_INTERFACE_CONTROL: reg_rdata_r <= reg_rd ? memory_interface_control_r : 32'h0000_0000;
            default: reg_rdata_r <= 32'h0000_0000;
         endcase
      end
   end
   // ---------------------------------------------------------------
   // one arbiter per slave bus
   // ---------------------------------------------------------------
   genvar b;
   generate
      for (b = 0; b < 2; b = b + 1) begin : g_bus
         localparam ST_IDLE = 2'd0;
         localparam ST_WAIT = 2'd1;   // locked winner waiting for drain
         localparam ST_LOCK = 2'd2;   // bus locked
         localparam ST_DRAIN = 2'd3;  // lock released, finishing
         wire [31:0] cfg = (b == 0) ? master_bus_arbitration_config_r : memory_port_arbitration_config_r;
         wire [4:0] req = (b == 0) ? mb_req : mc_req;
         wire use_rp = (b == 0) ? 1'b1 : memory_interface_control_r[`XBARB_MIC_REQPRI_BIT];
         reg [1:0] state_r;
         reg [2:0] owner_r;
         reg [3:0] rd_out_r;
         reg [3:0] wr_out_r;
         reg pav_r;
         reg lk_r;
         reg [2:0] gidx_r;
         wire [14:0] int_prio;
         wire gnt_any;
         wire [2:0] gnt_idx;
         wire idle = rd_out_r == 4'd0 && wr_out_r == 4'd0;
         // owner's lock: processor ports never lock
         wire own_lock = owner_r < 3'd2 && master_lock_request[owner_r[0]];
         reg [4:0] qreq;
         // while locked only the owner may be served; waiting or draining serves no one
         always @* begin
            case (state_r)
               ST_IDLE: qreq = req;
               ST_LOCK: qreq = req & (5'b00001 << owner_r);
               default: qreq = 5'b00000;
            endcase
         end
         xbarb_pick u_pick (
            .req(qreq),
            .req_prio(request_priority_bus),
            .use_req_prio(use_rp && state_r == ST_IDLE),
            .int_prio(int_prio),
            .gnt_any(gnt_any),
            .gnt_idx(gnt_idx)
         );
         // one address phase in flight; grant only when none is open
         wire fire = gnt_any && !pav_r;
         wire win_lock = fire && gnt_idx < 3'd2 && master_lock_request[gnt_idx[0]];
         // the register takes the word on the same edge, so reload from the bus data, not the stale register
         wire wr_me = (b == 0) ? wr_mb : wr_mc;
         xbarb_prio u_prio (
            .clk(clk),
            .nrst(nrst),
            .load(!seeded_r[1] || wr_me),
            .cfg_prio(wr_me ? reg_wdata[14:0] : cfg[`XBARB_FLD_PRIO0 +: 15]),
            .mode(cfg[`XBARB_FLD_MODE +: 2]),
            .gnt(fire && state_r != ST_WAIT),
            .gnt_idx(gnt_idx),
            .int_prio(int_prio)
         );
         // outstanding counts; an address ack is taken as a read and a write slot
         wire acc = pav_r && slave_address_ack[b];
         always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               rd_out_r <= 4'd0;
               wr_out_r <= 4'd0;
            end else begin
               rd_out_r <= rd_out_r + {3'd0, acc} - {3'd0, slave_read_complete[b] && rd_out_r != 4'd0};
               wr_out_r <= wr_out_r + {3'd0, acc} - {3'd0, slave_write_complete[b] && wr_out_r != 4'd0};
            end
         end
         // lock state machine and address valid generation
         always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               state_r <= ST_IDLE;
               owner_r <= 3'd0;
               pav_r <= 1'b0;
               lk_r <= 1'b0;
               gidx_r <= 3'd0;
            end else begin
               if (acc)
                  pav_r <= 1'b0;
               case (state_r)
                  ST_IDLE: begin
                     if (win_lock) begin
                        owner_r <= gnt_idx;
                        gidx_r <= gnt_idx;
                        if (idle) begin
                           state_r <= ST_LOCK;
                           pav_r <= 1'b1;
                           lk_r <= 1'b1;
                        end else begin
                           state_r <= ST_WAIT;
                        end
                     end else if (fire) begin
                        gidx_r <= gnt_idx;
                        pav_r <= 1'b1;
                     end
                  end
                  ST_WAIT: begin
                     if (idle && !pav_r) begin
                        state_r <= ST_LOCK;
                        pav_r <= 1'b1;
                        lk_r <= 1'b1;
                     end
                  end
                  ST_LOCK: begin
                     if (!own_lock) begin
                        state_r <= ST_DRAIN;
                        lk_r <= 1'b0;
                     end else if (fire) begin
                        gidx_r <= gnt_idx;
                        pav_r <= 1'b1;
                     end
                  end
                  ST_DRAIN: begin
                     if (idle && !pav_r)
                        state_r <= ST_IDLE;
                  end
                  default: state_r <= ST_IDLE;
               endcase
            end
         end
         // lock set with address valid at lock start, cleared as soon as the owner's lock request drops
         assign primary_address_valid[b] = pav_r;
         assign downstream_lock_output[b] = lk_r;
         assign grant_master[3*b +: 3] = gidx_r;
      end
   endgenerate
endmodule

// ===== xbarb_map.vh
`ifndef XBARB_MAP_VH
`define XBARB_MAP_VH
// control register bus offsets (printed offset 0x23 is a register index)
`define XBARB_OFS_MASTER_CFG 10'h023
`define XBARB_OFS_MEMORY_CFG 10'h024
`define XBARB_OFS_MEMORY_INTERFACE_CONTROL 10'h025
// arbitration register field positions (each master field is 3 bits)
`define XBARB_FLD_PRIO0 0
`define XBARB_FLD_WIDTH 3
`define XBARB_FLD_MODE 15
// mode encodings
`define XBARB_MODE_LRU 2'b00
`define XBARB_MODE_RR 2'b01
`define XBARB_MODE_FIXED 2'b10
// memory interface control: request-priority enable bit
`define XBARB_MIC_REQPRI_BIT 24
`define XBARB_MIC_RESET 32'h0100_0000
`define XBARB_NMASTER 5
`endif

// ===== xbarb_pick.v
`timescale 1ns/10ps
`include "xbarb_map.vh"
// ---------------------------------------------------------------
// combinational winner selection over five masters
// ---------------------------------------------------------------
module xbarb_pick (
   input wire [4:0] req,         // qualified requests
   input wire [9:0] req_prio,    // 2 bits per master
   input wire use_req_prio,      // request-priority level enabled
   input wire [14:0] int_prio,   // internal working priorities
   output reg gnt_any,           // some master wins
   output reg [2:0] gnt_idx      // index of winner
);
   reg [4:0] key [0:4];
   reg [4:0] best;
   integer i;
   // request priority first, master priority breaks ties
   always @* begin
      gnt_any = 1'b0;
      gnt_idx = 3'd0;
      best = 5'd0;
      for (i = 0; i < 5; i = i + 1) begin
         key[i] = {(use_req_prio ? req_prio[2*i +: 2] : 2'b00), int_prio[3*i +: 3]};
         if (req[i] && (!gnt_any || key[i] > best)) begin
            gnt_any = 1'b1;
            gnt_idx = i[2:0];
            best = key[i];
         end
      end
   end
endmodule

// ===== xbarb_prio.v
`timescale 1ns/10ps
`include "xbarb_map.vh"
// ---------------------------------------------------------------
// internal working priorities, updated per grant
// ---------------------------------------------------------------
module xbarb_prio (
   input wire clk,               // system clock
   input wire nrst,              // async reset, low
   input wire load,              // reload from config
   input wire [14:0] cfg_prio,   // register priorities
   input wire [1:0] mode,        // arbitration mode
   input wire gnt,               // one grant this cycle
   input wire [2:0] gnt_idx,     // granted master
   output wire [14:0] int_prio   // working priorities
);
   reg [14:0] prio_r;
   reg [14:0] prio_nxt;
   reg [2:0] gp;
   reg [2:0] p;
   integer i;
   assign int_prio = prio_r;
   // lru: winner to zero, lower ones move up; rr: rotate ring so winner is zero
   always @* begin
      prio_nxt = prio_r;
      gp = prio_r[3*gnt_idx +: 3];
      p = 3'd0;
      if (load) begin
         prio_nxt = cfg_prio;
      end else if (gnt && mode == `XBARB_MODE_LRU) begin
         for (i = 0; i < 5; i = i + 1) begin
            p = prio_r[3*i +: 3];
            if (i == gnt_idx)
               prio_nxt[3*i +: 3] = 3'd0;
            else if (p < gp)
               prio_nxt[3*i +: 3] = p + 3'd1;
         end
      end else if (gnt && mode == `XBARB_MODE_RR) begin
         // ring order is master index; winner 0, next index highest
         for (i = 0; i < 5; i = i + 1) begin
            p = (i > gnt_idx) ? 3'd5 - (i[2:0] - gnt_idx) : gnt_idx - i[2:0];
            prio_nxt[3*i +: 3] = p;
         end
      end else begin
         // fixed mode and no-grant cycles hold the copy, so starvation is possible
         prio_nxt = prio_r;
      end
   end
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         prio_r <= 15'h0000;
      else
         prio_r <= prio_nxt;
   end
endmodule

// ===== xbarb_slave_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// downstream slave on one arbiter bus
// ----------------------------------------
module xbarb_slave_model #(parameter int CMP_WAIT = 6) (
   input wire clk, // clock
   input wire nrst, // reset, low
   input wire [3:0] ack_wait, // extra cycles before ack
   input wire pav, // address valid
   output logic ack, // address ack pulse
   output logic rd_done, // read complete pulse
   output logic wr_done // write complete pulse
);
   int hold_r;
   int pend_r;
   int tmr_r;
   logic fin;
   assign fin = (pend_r > 0) && (tmr_r == CMP_WAIT);
   // ack after a chosen wait; each accepted address later retires one read
   // and one write, since the arbiter needs both counts empty to call it idle
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack <= 1'h0;
         rd_done <= 1'h0;
         wr_done <= 1'h0;
         hold_r <= 0;
         pend_r <= 0;
         tmr_r <= 0;
      end else begin
         ack <= 1'h0;
         if (pav && !ack) begin
            hold_r <= (hold_r >= ack_wait) ? 0 : hold_r + 1;
            ack <= (hold_r >= ack_wait);
         end
         rd_done <= fin;
         wr_done <= fin;
         tmr_r <= (pend_r > 0 && tmr_r < CMP_WAIT) ? tmr_r + 1 : 0;
         pend_r <= pend_r + (ack ? 1 : 0) - (fin ? 1 : 0);
      end
   end
endmodule

// ===== xbarb_checker.sv
`timescale 1ns/10ps
// ----------------------------------------
// arbiter port checker
// ----------------------------------------
module xbarb_checker (
   input wire clk, // clock
   input wire nrst, // reset, low
   input wire reg_rd, // read strobe
   input wire reg_wr, // write strobe
   input wire reg_ack_r, // access ack
   input wire [4:0] mb_req, // master bus requests
   input wire [9:0] request_priority_bus, // request levels
   input wire [1:0] master_lock_request, // lock inputs
   input wire [1:0] slave_address_ack, // address acks
   input wire [1:0] slave_read_complete, // read done
   input wire [1:0] slave_write_complete, // write done
   input wire [1:0] primary_address_valid, // address valid
   input wire [1:0] downstream_lock_output, // lock out
   input wire [5:0] grant_master // winners
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [4:0] req_q;
   logic [9:0] pri_q;
   logic [1:0] top_lvl;
   logic [2:0] own_r;
   logic [3:0] out_rd_r;
   logic [3:0] out_wr_r;
   logic dlo_q;
   // highest level carried by any requester the arbiter just sampled
   always @* begin
      top_lvl = 2'h0;
      for (int i = 0; i < 5; i++) if (req_q[i] && pri_q[2*i +: 2] > top_lvl) top_lvl = pri_q[2*i +: 2];
   end
   // sampled requests, lock owner and outstanding transfers per direction
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         req_q <= 5'h00;
         pri_q <= 10'h000;
         dlo_q <= 1'h0;
         own_r <= 3'h0;
         out_rd_r <= 4'h0;
         out_wr_r <= 4'h0;
      end else begin
         req_q <= mb_req;
         pri_q <= request_priority_bus;
         dlo_q <= downstream_lock_output[0];
         if (downstream_lock_output[0] && !dlo_q) own_r <= grant_master[2:0];
         out_rd_r <= out_rd_r + {3'h0, slave_address_ack[0]} - {3'h0, slave_read_complete[0]};
         out_wr_r <= out_wr_r + {3'h0, slave_address_ack[0]} - {3'h0, slave_write_complete[0]};
      end
   end
   grant_hold_a: assert property (primary_address_valid[0] && !slave_address_ack[0] |=>
      primary_address_valid[0] && $stable(grant_master[2:0])) else $error("master bus grant moved");
   mem_hold_a: assert property (primary_address_valid[1] && !slave_address_ack[1] |=>
      primary_address_valid[1] && $stable(grant_master[5:3])) else $error("memory grant moved");
   ack_close_a: assert property (primary_address_valid[0] && slave_address_ack[0] |=>
      !primary_address_valid[0]) else $error("address valid kept after ack");
   win_req_a: assert property ($rose(primary_address_valid[0]) |-> req_q[grant_master[2:0]])
      else $error("grant to idle master");
   level_wins_a: assert property ($rose(primary_address_valid[0]) && !downstream_lock_output[0] |->
      pri_q[2*grant_master[2:0] +: 2] == top_lvl) else $error("lower request level won");
   lock_start_a: assert property ($rose(downstream_lock_output[0]) |-> primary_address_valid[0] &&
      grant_master[2:0] <= 3'h1 && out_rd_r == 4'h0 && out_wr_r == 4'h0) else $error("bad lock start");
   lock_owner_a: assert property (dlo_q && downstream_lock_output[0] && $rose(primary_address_valid[0])
      |-> grant_master[2:0] == own_r) else $error("locked bus granted to other master");
   lock_end_a: assert property (downstream_lock_output[0] && master_lock_request == 2'h0 |=>
      !downstream_lock_output[0]) else $error("lock kept after release");
   reg_ack_a: assert property (reg_rd || reg_wr |=> reg_ack_r) else $error("register access not acked");
   ack_cause_a: assert property (reg_ack_r |-> $past(reg_rd || reg_wr)) else $error("stray register ack");
   cover property ($rose(downstream_lock_output[0]));
   cover property (primary_address_valid == 2'h3);
   cover property (reg_ack_r);
endmodule

bind xbarb_arbiter xbarb_checker i_xbarb_checker (.clk, .nrst, .reg_rd, .reg_wr, .reg_ack_r, .mb_req,
   .request_priority_bus, .master_lock_request, .slave_address_ack, .slave_read_complete,
   .slave_write_complete, .primary_address_valid, .downstream_lock_output, .grant_master);

// ===== xbarb_arbiter_tb_top.sv
`timescale 1ns/10ps
`include "xbarb_map.vh"
// ----------------------------------------
// arbiter testbench
// ----------------------------------------
module xbarb_arbiter_tb_top;
   localparam logic [31:0] ATTR_M = 32'h0001_4688; // fixed, master i has priority i
   localparam logic [31:0] ATTR_C = 32'h0000_4688; // lru, master i has priority i
   logic clk, nrst, reg_rd, reg_wr, reg_ack_r;
   logic [9:0] reg_addr, request_priority_bus;
   logic [31:0] reg_wdata, reg_rdata_r;
   logic [4:0] mb_req, mc_req;
   logic [1:0] master_lock_request, slave_address_ack, slave_read_complete, slave_write_complete;
   logic [1:0] primary_address_valid, downstream_lock_output;
   logic [5:0] grant_master;
   logic [3:0] ack_wait;
   int miscompares, total_checks;
   xbarb_arbiter i_xbarb_arbiter (.clk, .nrst, .attr_master_cfg(ATTR_M), .attr_memory_cfg(ATTR_C), .reg_rd,
      .reg_wr, .reg_addr, .reg_wdata, .reg_rdata_r, .reg_ack_r, .mb_req, .mc_req, .request_priority_bus,
      .master_lock_request, .slave_address_ack, .slave_read_complete, .slave_write_complete,
      .primary_address_valid, .downstream_lock_output, .grant_master);
   xbarb_slave_model i_xbarb_slave_model_0 (.clk, .nrst, .ack_wait, .pav(primary_address_valid[0]),
      .ack(slave_address_ack[0]), .rd_done(slave_read_complete[0]), .wr_done(slave_write_complete[0]));
   xbarb_slave_model i_xbarb_slave_model_1 (.clk, .nrst, .ack_wait, .pav(primary_address_valid[1]),
      .ack(slave_address_ack[1]), .rd_done(slave_read_complete[1]), .wr_done(slave_write_complete[1]));
   // 200 MHz clock
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // one register access; on a read, d is the value expected back
   task automatic reg_acc(input logic wr, input logic [9:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= wr;
      reg_rd <= !wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'h0;
      reg_rd <= 1'h0;
      @(negedge clk);
      chk({31'h0, reg_ack_r}, 32'h1);
      if (!wr) chk(reg_rdata_r, d);
   endtask
   // raise requests on both buses, check each winner, drop requests once granted
   task automatic round(input logic [4:0] m0, input logic [4:0] m1, input logic [9:0] pr,
         input logic [2:0] e0, input logic [2:0] e1, input logic lk);
      logic [1:0] seen;
      int n;
      seen = 2'h0;
      @(posedge clk);
      mb_req <= m0;
      mc_req <= m1;
      request_priority_bus <= pr;
      for (n = 0; n < 80 && seen != {|m1, |m0}; n++) begin
         @(negedge clk);
         if (primary_address_valid[0] === 1'h1 && !seen[0]) begin
            seen[0] = 1'h1;
            chk({29'h0, grant_master[2:0]}, {29'h0, e0});
            chk({31'h0, downstream_lock_output[0]}, {31'h0, lk});
         end
         if (primary_address_valid[1] === 1'h1 && !seen[1]) begin
            seen[1] = 1'h1;
            chk({29'h0, grant_master[5:3]}, {29'h0, e1});
            chk({31'h0, downstream_lock_output[1]}, {31'h0, lk});
         end
         @(posedge clk);
         if (seen[0]) mb_req <= 5'h00;
         if (seen[1]) mc_req <= 5'h00;
      end
      for (n = 0; n < 80 && primary_address_valid !== 2'h0; n++) @(negedge clk);
      // a missing grant or an address phase never acked both end the run
      if (seen != {|m1, |m0} || primary_address_valid !== 2'h0) begin
         miscompares++;
         $display("mismatch at %0t: no grant or address valid stuck", $time);
         stop_test();
      end
   endtask
   // main sequence
   initial begin
      {nrst, reg_rd, reg_wr, reg_addr, reg_wdata, mb_req, mc_req} = '0;
      {request_priority_bus, master_lock_request, ack_wait, miscompares, total_checks} = '0;
      repeat (3) @(posedge clk);
      nrst <= 1'h1;
      repeat (3) @(posedge clk);
      reg_acc(1'h0, `XBARB_OFS_MASTER_CFG, ATTR_M);
      reg_acc(1'h0, `XBARB_OFS_MEMORY_CFG, ATTR_C);
      reg_acc(1'h0, `XBARB_OFS_MEMORY_INTERFACE_CONTROL, `XBARB_MIC_RESET);
      reg_acc(1'h0, 10'h030, 32'h0);
      $display("test register reset done");
      round(5'h1F, 5'h1F, 10'h003, 3'h0, 3'h0, 1'h0);
      round(5'h1F, 5'h00, 10'h3FF, 3'h4, 3'h0, 1'h0);
      round(5'h1F, 5'h00, 10'h3FF, 3'h4, 3'h0, 1'h0);
      reg_acc(1'h1, `XBARB_OFS_MEMORY_INTERFACE_CONTROL, 32'h0);
      round(5'h00, 5'h1F, 10'h003, 3'h0, 3'h4, 1'h0);
      $display("test fixed and level done");
      reg_acc(1'h1, `XBARB_OFS_MASTER_CFG, 32'h0000_4688);
      round(5'h1F, 5'h00, 10'h3FF, 3'h4, 3'h0, 1'h0);
      round(5'h1F, 5'h00, 10'h3FF, 3'h3, 3'h0, 1'h0);
      round(5'h1F, 5'h00, 10'h3FF, 3'h2, 3'h0, 1'h0);
      round(5'h1F, 5'h00, 10'h00C, 3'h1, 3'h0, 1'h0);
      round(5'h1F, 5'h00, 10'h3FF, 3'h0, 3'h0, 1'h0);
      reg_acc(1'h0, `XBARB_OFS_MASTER_CFG, 32'h0000_4688);
      $display("test lru done");
      // round robin with reversed priorities: the new fields must decide the very next grant
      reg_acc(1'h1, `XBARB_OFS_MASTER_CFG, 32'h0000_829C);
      ack_wait <= 4'h3;
      round(5'h1F, 5'h00, 10'h3FF, 3'h0, 3'h0, 1'h0);
      round(5'h1F, 5'h00, 10'h3FF, 3'h1, 3'h0, 1'h0);
      round(5'h1F, 5'h00, 10'h3FF, 3'h2, 3'h0, 1'h0);
      $display("test round robin done");
      @(posedge clk);
      master_lock_request <= 2'h1;
      round(5'h05, 5'h01, 10'h003, 3'h0, 3'h0, 1'h1);
      round(5'h05, 5'h00, 10'h030, 3'h0, 3'h0, 1'h1);
      @(posedge clk);
      master_lock_request <= 2'h0;
      round(5'h04, 5'h00, 10'h030, 3'h2, 3'h0, 1'h0);
      $display("test lock done");
      stop_test();
   end
endmodule
